// ---- verification/pin_change_interrupt_tb.sv ----
// self-checking bench for the pin change interrupt block
// assumes ahb-lite single word transfers and one slave on the bus
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] level_req = 4'h0;
  logic sleep_mode = 1'b0;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [3:0] pin_in;
  wire logic change_irq;
  wire logic wake_req;
  wire logic irq;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] rd;

  always #20 hclk = ~hclk;

  pin_change_interrupt u_pin_change_interrupt (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_in(pin_in), .sleep_mode(sleep_mode), .change_irq(change_irq),
    .wake_req(wake_req), .irq(irq));
  pin_source u_pin_source (.level_req(level_req), .pin_out(pin_in));

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // returns right after the rising edge at which hready is high; rd holds hrdata of that edge
  task automatic wait_ready();
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
      @(negedge hclk);
    end
    rd = hrdata;
    @(posedge hclk);
  endtask

  // one single transfer; starts just after a rising edge
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= pin_change_pkg::HTRANS_NONSEQ;
    hwrite <= wr_en;
    hsize <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
  endtask

  // outputs looked at mid-cycle, where they have settled
  task automatic look(input string name, input logic [2:0] sel, input logic exp);
    logic got;
    @(negedge hclk);
    case (sel)
      3'h0: got = change_irq;
      3'h1: got = wake_req;
      3'h2: got = irq;
      3'h3: got = hresp;
      default: got = hreadyout;
    endcase
    check(name, {31'h0, exp}, {31'h0, got});
    @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic pins(input logic [3:0] v);
    level_req <= v;
    idle(6);
  endtask

  // clear only the flags already seen set
  task automatic clear_seen();
    bus(1'b0, pin_change_pkg::OFS_FLAGS, 32'h0);
    wr(pin_change_pkg::OFS_FLAGS, rd ^ 32'hff);
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a < 32; a += 4) rdchk("reset", a[7:0], 32'h0);
    look("hready_idle", 3'h4, 1'b1);
    wr(pin_change_pkg::OFS_RISE_EN, 32'hff);
    rdchk("rise_en", pin_change_pkg::OFS_RISE_EN, 32'hf);
    wr(pin_change_pkg::OFS_FALL_EN, 32'hff);
    rdchk("fall_en", pin_change_pkg::OFS_FALL_EN, 32'hf);
    wr(8'h1c, 32'hff);
    rdchk("unmapped", 8'h1c, 32'h0);
    // every combination of edge enables
    for (int m = 0; m < 4; m++) begin
      wr(pin_change_pkg::OFS_RISE_EN, m[0] ? 32'hf : 32'h0);
      wr(pin_change_pkg::OFS_FALL_EN, m[1] ? 32'hf : 32'h0);
      pins(4'hf);
      rdchk("flags_up", pin_change_pkg::OFS_FLAGS, m[0] ? 32'hf : 32'h0);
      pins(4'h0);
      rdchk("flags_down", pin_change_pkg::OFS_FLAGS, (m != 0) ? 32'hf : 32'h0);
      rdchk("summary", pin_change_pkg::OFS_CORE_CTRL, {31'h0, m != 0});
      look("change_irq_off", 3'h0, 1'b0);
      clear_seen();
      rdchk("flags_clr", pin_change_pkg::OFS_FLAGS, 32'h0);
    end
    wr(pin_change_pkg::OFS_RISE_EN, 32'h5);
    wr(pin_change_pkg::OFS_FALL_EN, 32'h0);
    pins(4'hf);
    rdchk("flags_subset", pin_change_pkg::OFS_FLAGS, 32'h5);
    wr(pin_change_pkg::OFS_CORE_CTRL, 32'h8);
    look("change_irq_on", 3'h0, 1'b1);
    rdchk("ctrl", pin_change_pkg::OFS_CORE_CTRL, 32'h9);
    wr(pin_change_pkg::OFS_FLAGS, 32'he);
    rdchk("flags_one", pin_change_pkg::OFS_FLAGS, 32'h4);
    wr(pin_change_pkg::OFS_CORE_CTRL, 32'h0);
    look("change_irq_main_off", 3'h0, 1'b0);
    // falling edge lands on the edge that ends a clearing write
    wr(pin_change_pkg::OFS_FALL_EN, 32'hf);
    clear_seen();
    level_req <= 4'h0;
    @(posedge hclk);
    wr(pin_change_pkg::OFS_FLAGS, 32'h0);
    idle(4);
    rdchk("flags_race", pin_change_pkg::OFS_FLAGS, 32'hf);
    // sleep and wake
    wr(pin_change_pkg::OFS_RISE_EN, 32'h1);
    clear_seen();
    wr(pin_change_pkg::OFS_CORE_CTRL, 32'h8);
    sleep_mode <= 1'b1;
    idle(2);
    look("wake_quiet", 3'h1, 1'b0);
    pins(4'h1);
    look("wake", 3'h1, 1'b1);
    sleep_mode <= 1'b0;
    rdchk("flags_sleep", pin_change_pkg::OFS_FLAGS, 32'h1);
    // sticky status, enable and clear
    rdchk("status", pin_change_pkg::OFS_IRQ_STATUS, 32'h3);
    look("irq_off", 3'h2, 1'b0);
    wr(pin_change_pkg::OFS_IRQ_ENABLE, 32'h3);
    look("irq_on", 3'h2, 1'b1);
    wr(pin_change_pkg::OFS_IRQ_STATUS, 32'h0);
    rdchk("status_ro", pin_change_pkg::OFS_IRQ_STATUS, 32'h3);
    wr(pin_change_pkg::OFS_IRQ_CLEAR, 32'h1);
    rdchk("status_clr", pin_change_pkg::OFS_IRQ_STATUS, 32'h2);
    wr(pin_change_pkg::OFS_IRQ_ENABLE, 32'h1);
    look("irq_masked", 3'h2, 1'b0);
    rdchk("irq_enable", pin_change_pkg::OFS_IRQ_ENABLE, 32'h1);
    wr(pin_change_pkg::OFS_IRQ_CLEAR, 32'h2);
    rdchk("status_empty", pin_change_pkg::OFS_IRQ_STATUS, 32'h0);
    look("hresp", 3'h3, 1'b0);
    // second reset in mid-run returns every register to zero
    hresetn <= 1'b0;
    idle(3);
    hresetn <= 1'b1;
    idle(1);
    for (int a = 0; a < 28; a += 4) rdchk("rerun", a[7:0], 32'h0);
    give_verdict();
  end
endmodule // pin_change_interrupt_tb
`default_nettype wire

// ---- verification/pin_source.sv ----
// external source that drives the four change-detect pins
// assumes the bench sets levels; pins move off the clock edge
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  // requested levels
  input wire logic [3:0] level_req,
  // pins
  output wire logic [3:0] pin_out
);
  // pins are unrelated to hclk, so settle 7 ns after a request
  assign #7 pin_out = level_req;
endmodule // pin_source
`default_nettype wire

// ---- verilog/pin_change_interrupt.sv ----
// pin change interrupt block with ahb-lite register slave
// assumes sleep_mode comes from hclk logic and pins are asynchronous
// Operation
// - four pins each detect edges; any combination can request the change interrupt
// - rise enable bit set: rising edge on that pin sets its flag
// - fall enable bit set: falling edge on that pin sets its flag
// - both enables set: edges of either polarity are flagged
// - both enables clear: pin never sets its flag
// - enabled edge sets the flag; request only while main enable set
// - main enable clear: flags still set, no interrupt request; the edge status bit still sets, so irq asserts if its enable bit is set
// - summary flag high exactly while any pin flag is set
// - writing zero to a flag bit clears that flag
// - edge during a clearing write leaves the flag set
// - main enable set: change sequence wakes the core from sleep
// - edge in sleep is in the flag register before wake
// - upper bits read zero; enable and main enable bits read/write, flags and status only clear, all reset to zero
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt #(
  parameter int unsigned PINS = pin_change_pkg::PIN_COUNT
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pins and core
  input wire logic [PINS-1:0] pin_in,
  input wire logic sleep_mode,
  output logic change_irq,
  output logic wake_req,
  output logic irq
);
  localparam int unsigned EVTS = pin_change_pkg::EVT_COUNT;

  function automatic logic [31:0] pad_word(input logic [7:0] v);
    pad_word = {24'h000000, v};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // state
  logic [PINS-1:0] rise_en_reg;
  logic [PINS-1:0] fall_en_reg;
  logic [PINS-1:0] flags_reg;
  logic main_en_reg;
  logic [EVTS-1:0] status_reg;
  logic [EVTS-1:0] irq_en_reg;
  logic dp_wr_reg;
  logic [7:0] dp_addr_reg;
  logic [31:0] hrdata_reg;

  logic [PINS-1:0] rise_en_next;
  logic [PINS-1:0] fall_en_next;
  logic [PINS-1:0] flags_next;
  logic main_en_next;
  logic [EVTS-1:0] status_next;
  logic [EVTS-1:0] irq_en_next;

  // edge detection
  logic [PINS-1:0] rise_pulse;
  logic [PINS-1:0] fall_pulse;

  pin_edge_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(pin_in),
    .rise_pulse(rise_pulse),
    .fall_pulse(fall_pulse)
  );

  // bus decode
  wire ap_valid = hsel && htrans == pin_change_pkg::HTRANS_NONSEQ;
  wire ap_take = ap_valid && hready;
  wire [7:0] ap_addr = haddr[7:0];
  wire hi_clear = haddr[31:8] == 24'h000000;
  // a read right behind a write waits one cycle to see the new value
  wire rd_stall = dp_wr_reg && ap_valid && !hwrite;
  wire wr_now = dp_wr_reg;
  wire wr_rise = wr_now && hit(dp_addr_reg, pin_change_pkg::OFS_RISE_EN);
  wire wr_fall = wr_now && hit(dp_addr_reg, pin_change_pkg::OFS_FALL_EN);
  wire wr_flags = wr_now && hit(dp_addr_reg, pin_change_pkg::OFS_FLAGS);
  wire wr_ctrl = wr_now && hit(dp_addr_reg, pin_change_pkg::OFS_CORE_CTRL);
  wire wr_clr = wr_now && hit(dp_addr_reg, pin_change_pkg::OFS_IRQ_CLEAR);
  wire wr_ien = wr_now && hit(dp_addr_reg, pin_change_pkg::OFS_IRQ_ENABLE);

  // flag set terms
  wire [PINS-1:0] rise_hit = rise_pulse & rise_en_reg;
  wire [PINS-1:0] fall_hit = fall_pulse & fall_en_reg;
  wire [PINS-1:0] set_vec = rise_hit | fall_hit;
  // write keeps ones and clears zeros
  wire [PINS-1:0] keep_mask = wr_flags ? hwdata[PINS-1:0] : {PINS{1'b1}};
  wire summary = |flags_reg;

  // events
  wire [EVTS-1:0] evt_vec;
  assign evt_vec[pin_change_pkg::EVT_EDGE_BIT] = |set_vec;
  assign evt_vec[pin_change_pkg::EVT_WAKE_BIT] = sleep_mode && main_en_reg && |set_vec;
  wire [EVTS-1:0] clr_vec = wr_clr ? hwdata[EVTS-1:0] : '0;

  // next state
  assign rise_en_next = wr_rise ? hwdata[PINS-1:0] : rise_en_reg;
  assign fall_en_next = wr_fall ? hwdata[PINS-1:0] : fall_en_reg;
  // set wins over a clearing write
  assign flags_next = (flags_reg & keep_mask) | set_vec;
  assign main_en_next = wr_ctrl ? hwdata[pin_change_pkg::CTRL_MAIN_EN_BIT] : main_en_reg;
  assign status_next = (status_reg & ~clr_vec) | evt_vec;
  assign irq_en_next = wr_ien ? hwdata[EVTS-1:0] : irq_en_reg;

  // read mux
  logic [7:0] ctrl_byte;
  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[pin_change_pkg::CTRL_MAIN_EN_BIT] = main_en_reg;
    ctrl_byte[pin_change_pkg::CTRL_SUMMARY_BIT] = summary;
  end

  wire [7:0] rise_byte = 8'(rise_en_reg);
  wire [7:0] fall_byte = 8'(fall_en_reg);
  wire [7:0] flag_byte = 8'(flags_reg);
  wire [7:0] stat_byte = 8'(status_reg);
  wire [7:0] ien_byte = 8'(irq_en_reg);

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h00000000;
    if (hi_clear) begin
      case (ap_addr)
        pin_change_pkg::OFS_RISE_EN: rd_val = pad_word(rise_byte);
        pin_change_pkg::OFS_FALL_EN: rd_val = pad_word(fall_byte);
        pin_change_pkg::OFS_FLAGS: rd_val = pad_word(flag_byte);
        pin_change_pkg::OFS_CORE_CTRL: rd_val = pad_word(ctrl_byte);
        pin_change_pkg::OFS_IRQ_STATUS: rd_val = pad_word(stat_byte);
        pin_change_pkg::OFS_IRQ_ENABLE: rd_val = pad_word(ien_byte);
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  // bus phase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else begin
      dp_wr_reg <= ap_take && hwrite && hi_clear;
      if (ap_take) begin
        dp_addr_reg <= ap_addr;
      end
      if (ap_take && !hwrite) begin
        hrdata_reg <= rd_val;
      end
    end
  end

  // block registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_en_reg <= PINS'(pin_change_pkg::RST_RISE_EN);
      fall_en_reg <= PINS'(pin_change_pkg::RST_FALL_EN);
      flags_reg <= PINS'(pin_change_pkg::RST_FLAGS);
      main_en_reg <= pin_change_pkg::RST_MAIN_EN;
      status_reg <= pin_change_pkg::RST_IRQ_STATUS;
      irq_en_reg <= pin_change_pkg::RST_IRQ_ENABLE;
    end else begin
      rise_en_reg <= rise_en_next;
      fall_en_reg <= fall_en_next;
      flags_reg <= flags_next;
      main_en_reg <= main_en_next;
      status_reg <= status_next;
      irq_en_reg <= irq_en_next;
    end
  end

  // outputs
  assign hreadyout = !rd_stall;
  assign hresp = pin_change_pkg::HRESP_OKAY;
  assign hrdata = hrdata_reg;
  assign change_irq = main_en_reg && summary;
  assign wake_req = sleep_mode && main_en_reg && summary;
  assign irq = |(status_reg & irq_en_reg);

  // checks
  property p_rise_sets;
    @(posedge hclk) disable iff (!hresetn)
      (rise_pulse & rise_en_reg) != '0
        |=> (flags_reg & $past(rise_pulse & rise_en_reg)) == $past(rise_pulse & rise_en_reg);
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("enabled rising edge did not set flag");

  property p_fall_sets;
    @(posedge hclk) disable iff (!hresetn)
      (fall_pulse & fall_en_reg) != '0
        |=> (flags_reg & $past(fall_pulse & fall_en_reg)) == $past(fall_pulse & fall_en_reg);
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("enabled falling edge did not set flag");

  property p_both_edges;
    @(posedge hclk) disable iff (!hresetn)
      rise_en_reg[0] && fall_en_reg[0] && (rise_pulse[0] || fall_pulse[0]) |=> flags_reg[0];
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("dual enable pin missed an edge");

  property p_disabled_quiet;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (flags_reg & ~$past(flags_reg) & ~$past(rise_en_reg | fall_en_reg)) == '0;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("flag set on a pin with no edge enabled");

  property p_req_follows;
    @(posedge hclk) disable iff (!hresetn)
      main_en_reg && set_vec != '0 && !wr_ctrl |=> change_irq;
  endproperty
  a_req_follows: assert property (p_req_follows)
    else $error("enabled edge gave no change request");

  property p_no_req_off;
    @(posedge hclk) disable iff (!hresetn)
      !main_en_reg && set_vec != '0 |-> !change_irq ##1 summary;
  endproperty
  a_no_req_off: assert property (p_no_req_off)
    else $error("request with main enable off or flag lost");

  property p_summary;
    @(posedge hclk) disable iff (!hresetn)
      ap_take && !hwrite && hi_clear && ap_addr == pin_change_pkg::OFS_CORE_CTRL
        |=> hrdata[pin_change_pkg::CTRL_SUMMARY_BIT] == ($past(flags_reg) != '0);
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary flag disagrees with pin flags");

  property p_clear_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_flags |=> flags_reg == (($past(flags_reg) & $past(hwdata[PINS-1:0])) | $past(set_vec));
  endproperty
  a_clear_write: assert property (p_clear_write)
    else $error("flag write did not clear as written");

  property p_set_wins;
    @(posedge hclk) disable iff (!hresetn)
      wr_flags && set_vec != '0 |=> (flags_reg & $past(set_vec)) == $past(set_vec);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("edge lost during clearing write");

  property p_wake;
    @(posedge hclk) disable iff (!hresetn)
      sleep_mode && main_en_reg && set_vec != '0 && !wr_ctrl |=> wake_req || !sleep_mode;
  endproperty
  a_wake: assert property (p_wake)
    else $error("edge in sleep did not wake");

  property p_wake_flagged;
    @(posedge hclk) disable iff (!hresetn)
      $rose(wake_req) |-> flags_reg != '0;
  endproperty
  a_wake_flagged: assert property (p_wake_flagged)
    else $error("wake without a recorded flag");

  property p_upper_zero;
    @(posedge hclk) disable iff (!hresetn)
      ap_take && !hwrite ##1 hready |-> hrdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unimplemented read bits not zero");

  property p_flag_hold;
    @(posedge hclk) disable iff (!hresetn)
      (~flags_reg & $past(flags_reg)) != '0 |-> $past(wr_flags);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag cleared without a flag write");

  property p_status_sticky;
    @(posedge hclk) disable iff (!hresetn)
      (~status_reg & $past(status_reg) & ~$past(clr_vec)) == '0;
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status bit dropped without a clear");

  property p_stall_short;
    @(posedge hclk) disable iff (!hresetn)
      !hreadyout |=> hreadyout;
  endproperty
  a_stall_short: assert property (p_stall_short)
    else $error("bus wait longer than one cycle");

  property p_en_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_rise |=> rise_en_reg == $past(hwdata[PINS-1:0]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("rise enable write did not land");

  property p_flag_read;
    @(posedge hclk) disable iff (!hresetn)
      ap_take && !hwrite && hi_clear && ap_addr == pin_change_pkg::OFS_FLAGS
        |=> hrdata == pad_word(8'($past(flags_reg)));
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flag read returned wrong value");

  property p_main_gate;
    @(posedge hclk) disable iff (!hresetn)
      !main_en_reg |-> !change_irq && !wake_req;
  endproperty
  a_main_gate: assert property (p_main_gate)
    else $error("request or wake with main enable off");

  property p_wake_status;
    @(posedge hclk) disable iff (!hresetn)
      sleep_mode && main_en_reg && set_vec != '0 |=> status_reg[pin_change_pkg::EVT_WAKE_BIT];
  endproperty
  a_wake_status: assert property (p_wake_status)
    else $error("edge in sleep left no wake status");

  property p_ien_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_ien |=> irq_en_reg == $past(hwdata[EVTS-1:0]);
  endproperty
  a_ien_write: assert property (p_ien_write)
    else $error("irq enable write did not land");

  c_edge_irq: cover property (@(posedge hclk) disable iff (!hresetn)
    set_vec != '0 ##1 change_irq);
  c_clear_race: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_flags && set_vec != '0);
  c_wake: cover property (@(posedge hclk) disable iff (!hresetn) $rose(wake_req));
  c_read_stall: cover property (@(posedge hclk) disable iff (!hresetn) rd_stall);
  c_dual_fall: cover property (@(posedge hclk) disable iff (!hresetn)
    (rise_en_reg & fall_en_reg & fall_pulse) != '0);
endmodule // pin_change_interrupt
`default_nettype wire

// ---- verilog/pin_change_pkg.sv ----
// constants for the pin change interrupt block
// assumes a 32-bit ahb-lite register bus with byte addresses
package pin_change_pkg;
  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned ADDR_DECODE_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_RISE_EN = 8'h00;
  localparam logic [7:0] OFS_FALL_EN = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  // reset values
  localparam logic [3:0] RST_RISE_EN = 4'h0;
  localparam logic [3:0] RST_FALL_EN = 4'h0;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic RST_MAIN_EN = 1'b0;
  localparam logic [1:0] RST_IRQ_STATUS = 2'h0;
  localparam logic [1:0] RST_IRQ_ENABLE = 2'h0;
  // core interrupt control field positions
  localparam int unsigned CTRL_MAIN_EN_BIT = 3;
  localparam int unsigned CTRL_SUMMARY_BIT = 0;
  // sticky event bits
  localparam int unsigned EVT_COUNT = 2;
  localparam int unsigned EVT_EDGE_BIT = 0;
  localparam int unsigned EVT_WAKE_BIT = 1;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

// ---- verilog/pin_edge_sync.sv ----
// two-stage synchroniser and edge finder for asynchronous pins
// assumes pins are unrelated to hclk
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync #(
  parameter int unsigned WIDTH = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // raw pins
  input wire logic [WIDTH-1:0] pin_in,
  // edge pulses
  output logic [WIDTH-1:0] rise_pulse,
  output logic [WIDTH-1:0] fall_pulse
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // sample compared with previous sample
  assign rise_pulse = sync_reg & ~prev_reg;
  assign fall_pulse = ~sync_reg & prev_reg;

  property p_edge_exclusive;
    @(posedge hclk) disable iff (!hresetn)
      (rise_pulse & fall_pulse) == '0 ##0 (rise_pulse != '0) |=> (rise_pulse & fall_pulse) == '0;
  endproperty
  a_edge_exclusive: assert property (p_edge_exclusive)
    else $error("rise and fall on same pin at once");

  property p_rise_from_low;
    @(posedge hclk) disable iff (!hresetn)
      $rose(sync_reg[0]) |-> rise_pulse[0] ##1 !rise_pulse[0];
  endproperty
  a_rise_from_low: assert property (p_rise_from_low)
    else $error("rising sample not reported once");
endmodule // pin_edge_sync
`default_nettype wire
